/* File: dv/cehi_can_node.sv */
module cehi_can_node (
  input  wire logic             clk,
  input  wire logic             hold,
  input  wire logic             slow,
  output logic                  tx_ready,
  output cehi_pkg::cehi_frame_t rx_frame,
  output logic                  rx_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  import cehi_pkg::*;
  int seed = 15338;
  initial
  begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_frame = '0;
  end
  // Busy controller stalls while hold is high, and at random while slow is high
  always @(posedge clk)
    tx_ready <= !hold && (!slow || ($random(seed) & 1) == 1);
  // Frames arrive unasked; data lines scrambled between strobes
  task automatic send(input cehi_frame_t f);
    @(posedge clk);
    rx_frame <= f;
    rx_valid <= 1'b1;
    @(posedge clk);
    rx_frame <= ~f;
    rx_valid <= 1'b0;
  endtask
endmodule

/* File: dv/cehi_top_chk.sv */
module cehi_top_chk (
  input wire logic                  CLK,
  input wire logic                  RESET,
  input wire logic                  WB_CYC_I,
  input wire logic                  WB_STB_I,
  input wire logic                  WB_ACK_O,
  input wire cehi_pkg::cehi_frame_t TX_FRAME,
  input wire logic                  TX_VALID,
  input wire logic                  TX_READY,
  input wire logic [15:0]           BIT_RATE,
  input wire logic [6:0]            LOAD_ID,
  input wire logic                  INIT_PULSE,
  input wire logic                  TX_ACCEPT
);
  timeunit 1ns;
  timeprecision 1ps;
  import cehi_pkg::*;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  ack_follows_req_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("bus request without ack");
  ack_one_cycle_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  accept_pulse_a: assert property (TX_ACCEPT |=> !TX_ACCEPT)
    else $error("accept longer than one cycle");
  init_pulse_a: assert property (INIT_PULSE |=> !INIT_PULSE)
    else $error("init pulse longer than one cycle");
  accept_offers_a: assert property (TX_ACCEPT |-> ##[0:3] TX_VALID)
    else $error("accepted frame never offered");
  frame_held_a: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_FRAME))
    else $error("offered frame changed while busy");
  rate_legal_a: assert property (BIT_RATE inside {16'h0032, 16'h0064, 16'h007d, 16'h00fa, 16'h01f4, 16'h03e8})
    else $error("illegal active bit rate");
  load_id_range_a: assert property (LOAD_ID != 7'h00)
    else $error("load id zero");
  tx_dlc_max_a: assert property (TX_VALID |-> TX_FRAME.dlc <= DLC_MAX)
    else $error("more than eight bytes offered");
  tx_std_id_a: assert property (TX_VALID && !TX_FRAME.ext |-> TX_FRAME.id <= 29'h7ff)
    else $error("normal frame id above 11 bits");
endmodule

bind cehi_top cehi_top_chk u_cehi_top_chk (.CLK, .RESET, .WB_CYC_I, .WB_STB_I, .WB_ACK_O, .TX_FRAME,
  .TX_VALID, .TX_READY, .BIT_RATE, .LOAD_ID, .INIT_PULSE, .TX_ACCEPT);

/* File: dv/tb_cehi_top.sv */
module tb_cehi_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cehi_pkg::*;
  logic        clk, reset, cyc, stb, we, ack, txv, txr, rxv, initp, acc, extm, hold, slow;
  logic [7:0]  adr;
  logic [3:0]  sel, ovf;
  logic [31:0] dati, dato;
  logic [15:0] rate;
  logic [6:0]  lid;
  logic [63:0] e, exp_rd[$];
  cehi_frame_t txf, rxf, f, ef, fr[4], exp_tx[$];
  int          n_mismatch, total_checks, cycles, n_acc, n_init, a;
  int          seed = 15338;
  logic [15:0] rates[6] = '{16'h0032, 16'h0064, 16'h007d, 16'h00fa, 16'h01f4, 16'h03e8};

  cehi_top u_cehi_top (.CLK(clk), .RESET(reset), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dati), .WB_DAT_O(dato), .WB_ACK_O(ack), .TX_FRAME(txf),
    .TX_VALID(txv), .TX_READY(txr), .RX_FRAME(rxf), .RX_VALID(rxv), .BIT_RATE(rate), .EXT_MODE(extm),
    .LOAD_ID(lid), .INIT_PULSE(initp), .TX_ACCEPT(acc), .RX_OVERFLOW(ovf));
  cehi_can_node u_cehi_can_node (.clk(clk), .hold(hold), .slow(slow), .tx_ready(txr), .rx_frame(rxf),
    .rx_valid(rxv));

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= ad;
    dati <= d;
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] x);
    exp_rd.push_back({m, x});
    wb(1'b0, ad, 32'h0);
  endtask

  function automatic cehi_frame_t mk(input logic x, input logic [28:0] id, input logic [3:0] dl);
    mk = '{x, id, (dl > DLC_MAX) ? DLC_MAX : dl, {$random(seed), $random(seed)}};
  endfunction

  // Raw length code goes to the bus, capped one is expected
  task automatic go(input cehi_frame_t t, input logic [3:0] dl, input int x);
    a = n_acc;
    wb(1'b1, OFS_TX_ID, 32'(t.id));
    wb(1'b1, OFS_TX_DLC, 32'(dl));
    wb(1'b1, OFS_TX_DLO, t.data[31:0]);
    wb(1'b1, OFS_TX_DHI, t.data[63:32]);
    wb(1'b1, OFS_TX_CTRL, 32'h3);
    repeat (3) @(posedge clk);
    chk(32'(n_acc - a), 32'(x));
  endtask

  task automatic drain();
    for (int i = 0; i < 300 && exp_tx.size() > 0; i++)
      @(posedge clk);
    chk(32'(exp_tx.size()), 32'h0);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    n_acc  += (acc === 1'b1);
    n_init += (initp === 1'b1);
    if (ack === 1'b1 && we === 1'b0 && exp_rd.size() > 0)
    begin
      e = exp_rd.pop_front();
      chk(dato & e[63:32], e[31:0]);
    end
    if (txv === 1'b1 && txr === 1'b1)
    begin
      ef = (exp_tx.size() > 0) ? exp_tx.pop_front() : '1;
      chk(32'(txf !== ef), 32'h0);
    end
    if (cycles == 20000)
    begin
      n_mismatch++;
      summarize();
    end
  end

  initial
  begin
    reset = 1'b1;
    cyc   = 1'b0;
    stb   = 1'b0;
    we    = 1'b0;
    adr   = 8'h00;
    sel   = 4'hf;
    dati  = 32'h0;
    hold  = 1'b0;
    slow  = 1'b0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk(32'(rate), 32'(BIT_RATE_RST));
    rd(OFS_BIT_RATE, 32'hffffffff, 32'h007d007d);
    foreach (rates[k])
    begin
      wb(1'b1, OFS_BIT_RATE, 32'(rates[k]));
      rd(OFS_BIT_RATE, 32'h0000ffff, 32'(rates[k]));
    end
    wb(1'b1, OFS_BIT_RATE, 32'h0320);
    rd(OFS_BIT_RATE, 32'hffffffff, 32'h007d03e8);
    wb(1'b1, OFS_LOAD_ID, 32'h100);
    wb(1'b1, OFS_LOAD_ID, 32'h005);
    rd(OFS_LOAD_ID, 32'h7f, 32'h7f);
    wb(1'b1, OFS_LOAD_ID, 32'h105);
    rd(OFS_LOAD_ID, 32'h7f, 32'h05);
    chk(32'(lid), 32'h7f);
    wb(1'b1, OFS_INIT, 32'h8);
    @(posedge clk);
    chk(32'(rate), 32'h3e8);
    chk(32'(lid), 32'h05);
    $display("test settings done");
    a = n_init;
    wb(1'b1, OFS_INIT, 32'h7);
    repeat (2) @(posedge clk);
    chk(32'(n_init - a), 32'h1);
    chk(32'(extm), 32'h1);
    rd(OFS_INIT, 32'h15, 32'h15);
    wb(1'b1, OFS_TX_CTRL, 32'h1);
    hold <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      fr[k] = mk(1'b1, {5'(4 - k), 24'($random(seed))}, 4'(k * 5));
      go(fr[k], 4'(k * 5), 1);
    end
    exp_tx = '{fr[0], fr[3], fr[2], fr[1]};
    hold <= 1'b0;
    slow <= 1'b1;
    drain();
    rd(OFS_TX_CTRL, 32'hf, 32'h5);
    wb(1'b1, OFS_TX_CTRL, 32'h5);
    rd(OFS_TX_CTRL, 32'hf, 32'h1);
    $display("test extended transmit done");
    wb(1'b1, OFS_INIT, 32'h3);
    wb(1'b1, OFS_TX_CTRL, 32'h1);
    chk(32'(extm), 32'h0);
    go(mk(1'b0, 29'h800, 4'h2), 4'h2, 0);
    f = mk(1'b0, 29'h7ff, 4'h8);
    exp_tx.push_back(f);
    go(f, 4'h8, 1);
    drain();
    wb(1'b1, OFS_TX_CTRL, 32'h0);
    go(f, 4'h8, 0);
    chk(32'(txv), 32'h0);
    exp_tx.push_back(f);
    go(f, 4'h8, 1);
    drain();
    $display("test normal transmit done");
    wb(1'b1, OFS_RX_CFGID, 32'h123);
    wb(1'b1, OFS_RX_CTRL, 32'h4);
    u_cehi_can_node.send(mk(1'b1, 29'h123, 4'h1));
    u_cehi_can_node.send(mk(1'b0, 29'h124, 4'h1));
    f = mk(1'b0, 29'h123, 4'h4);
    u_cehi_can_node.send(f);
    repeat (7) u_cehi_can_node.send(mk(1'b0, 29'h123, 4'h1));
    rd(OFS_RX_STAT, 32'h30f, 32'h208);
    u_cehi_can_node.send(mk(1'b0, 29'h123, 4'h1));
    rd(OFS_RX_STAT, 32'h30f, 32'h308);
    chk(32'(ovf), 32'h1);
    wb(1'b1, OFS_RX_CTRL, 32'h10);
    rd(OFS_RX_DLO, 32'hffffffff, f.data[31:0]);
    rd(OFS_RX_STAT, 32'hf, 32'h7);
    for (int k = 6; k > 3; k--)
    begin
      wb(1'b1, OFS_RX_CTRL, 32'h10);
      rd(OFS_RX_STAT, 32'hf, 32'(k));
    end
    wb(1'b1, OFS_RX_CTRL, 32'h8);
    wb(1'b1, OFS_RX_CTRL, 32'h0);
    rd(OFS_RX_STAT, 32'h10f, 32'h0);
    chk(32'(ovf), 32'h0);
    wb(1'b1, OFS_RX_CTRL, 32'h10);
    rd(OFS_RX_ID, 32'hffffffff, 32'h0);
    $display("test receive done");
    summarize();
  end
endmodule

/* File: rtl/cehi_pkg.sv */
// Overview of operation
// - With enable set, store program-load ID; only values 1 to 127 are taken.
// - A start request initialises the interface; start low means initialisation is done.
// - Extended select high gives 29-bit identifiers, low gives 11-bit identifiers.
// - Bit rate accepts 50, 100, 125, 250, 500, 1000 kbit/s; default 125.
// - A newly written bit rate applies only after a restart of the device.
// - Taking over a transmit request gives a one-cycle acceptance pulse.
// - Transmit ID range is 0..2047 in 11-bit mode, 0..536870911 in 29-bit.
// - Length code picks bytes from eight data bytes; never more than eight sent.
// - Transmit enable low: requests ignored and no acceptance pulse; frames already pending are still offered.
// - About one transmit request per millisecond at 125 kbit/s, not guaranteed.
// - Each receive read pops one entry and lowers pending count; zero means empty.
// - Overflow flag rises when a queue lost a message because it was full.
// - While clear is high, the selected receive queue discards all entries.
// - Receive ID is 11 bits in normal mode, 29 bits in extended mode.
// - A separate FIFO per configured identifier fills without host action.
// - Of several waiting messages, the lowest identifier is sent first; a frame already offered stays offered until taken or a start or soft reset flushes it.
// - While all four transmit slots are full, new requests are refused by withholding acceptance.
package cehi_pkg;

  localparam int RX_OBJS  = 4;
  localparam int RX_DEPTH = 8;
  localparam int TX_SLOTS = 4;

  localparam logic [7:0] OFS_LOAD_ID  = 8'h00;
  localparam logic [7:0] OFS_INIT     = 8'h04;
  localparam logic [7:0] OFS_BIT_RATE = 8'h08;
  localparam logic [7:0] OFS_TX_CTRL  = 8'h0c;
  localparam logic [7:0] OFS_TX_ID    = 8'h10;
  localparam logic [7:0] OFS_TX_DLC   = 8'h14;
  localparam logic [7:0] OFS_TX_DLO   = 8'h18;
  localparam logic [7:0] OFS_TX_DHI   = 8'h1c;
  localparam logic [7:0] OFS_RX_CTRL  = 8'h20;
  localparam logic [7:0] OFS_RX_CFGID = 8'h24;
  localparam logic [7:0] OFS_RX_STAT  = 8'h28;
  localparam logic [7:0] OFS_RX_ID    = 8'h2c;
  localparam logic [7:0] OFS_RX_DLC   = 8'h30;
  localparam logic [7:0] OFS_RX_DLO   = 8'h34;
  localparam logic [7:0] OFS_RX_DHI   = 8'h38;

  // Field positions
  localparam int LID_EN_BIT    = 8;
  localparam int INIT_EN_BIT   = 0;
  localparam int INIT_START    = 1;
  localparam int INIT_EXT_BIT  = 2;
  localparam int INIT_SOFT_RST = 3;
  localparam int INIT_EXT_ACT  = 4;
  localparam int TXC_EN_BIT    = 0;
  localparam int TXC_GO_BIT    = 1;
  localparam int TXC_DONE_BIT  = 2;
  localparam int TXC_FULL_BIT  = 3;
  localparam int RXC_SEL_LSB   = 0;
  localparam int RXC_CFG_BIT   = 2;
  localparam int RXC_CLR_BIT   = 3;
  localparam int RXC_READ_BIT  = 4;
  localparam int RXS_OVF_BIT   = 8;
  localparam int RXS_CFG_BIT   = 9;

  // Reset values and limits
  localparam logic [6:0]  LOAD_ID_RST  = 7'h7f;
  localparam logic [15:0] BIT_RATE_RST = 16'h007d;
  localparam logic [10:0] STD_ID_MAX   = 11'h7ff;
  localparam logic [3:0]  DLC_MAX      = 4'h8;

  typedef struct packed {
    logic        ext;
    logic [28:0] id;
    logic [3:0]  dlc;
    logic [63:0] data;
  } cehi_frame_t;

  function automatic logic rate_ok(input logic [15:0] r);
    rate_ok = (r == 16'h0032) || (r == 16'h0064) || (r == 16'h007d) ||
              (r == 16'h00fa) || (r == 16'h01f4) || (r == 16'h03e8);
  endfunction

  function automatic logic [31:0] wmask(input logic [3:0] sel, input logic [31:0] old, input logic [31:0] dat);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    wmask = (old & ~m) | (dat & m);
  endfunction

endpackage

/* File: rtl/cehi_rx_queue.sv */
module cehi_rx_queue (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 flush,
  input  wire logic                 push,
  input  wire cehi_pkg::cehi_frame_t push_frame,
  input  wire logic                 pop,
  output cehi_pkg::cehi_frame_t     head,
  output logic [3:0]                count,
  output logic                      overflow
);
  import cehi_pkg::*;

  cehi_frame_t mem [RX_DEPTH];
  logic [2:0]  wr_ff;
  logic [2:0]  rd_ff;
  logic [3:0]  cnt_ff;
  logic        ovf_ff;
  logic [2:0]  nxt_wr;
  logic [2:0]  nxt_rd;
  logic [3:0]  nxt_cnt;
  logic        nxt_ovf;
  logic        do_pop;
  logic        do_push;

  always_comb
  begin
    do_pop  = pop && (cnt_ff != 4'h0);
    do_push = push && ((cnt_ff != 4'(RX_DEPTH)) || do_pop);
    nxt_wr  = do_push ? wr_ff + 3'h1 : wr_ff;
    nxt_rd  = do_pop ? rd_ff + 3'h1 : rd_ff;
    nxt_cnt = cnt_ff + {3'h0, do_push} - {3'h0, do_pop};
    nxt_ovf = ovf_ff || (push && !do_push);
    if (flush)
    begin
      nxt_wr  = 3'h0;
      nxt_rd  = 3'h0;
      nxt_cnt = 4'h0;
      nxt_ovf = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wr_ff  <= 3'h0;
      rd_ff  <= 3'h0;
      cnt_ff <= 4'h0;
      ovf_ff <= 1'b0;
    end
    else
    begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
      ovf_ff <= nxt_ovf;
    end
  end

  always_ff @(posedge clk)
  begin
    if (do_push && !flush)
      mem[wr_ff] <= push_frame;
  end

  assign head     = mem[rd_ff];
  assign count    = cnt_ff;
  assign overflow = ovf_ff;
endmodule

/* File: rtl/cehi_top.sv */
module cehi_top (
  input  wire logic                  CLK,
  input  wire logic                  RESET,
  input  wire logic                  WB_CYC_I,
  input  wire logic                  WB_STB_I,
  input  wire logic                  WB_WE_I,
  input  wire logic [7:0]            WB_ADR_I,
  input  wire logic [3:0]            WB_SEL_I,
  input  wire logic [31:0]           WB_DAT_I,
  output logic [31:0]                WB_DAT_O,
  output logic                       WB_ACK_O,
  output cehi_pkg::cehi_frame_t      TX_FRAME,
  output logic                       TX_VALID,
  input  wire logic                  TX_READY,
  input  wire cehi_pkg::cehi_frame_t RX_FRAME,
  input  wire logic                  RX_VALID,
  output logic [15:0]                BIT_RATE,
  output logic                       EXT_MODE,
  output logic [6:0]                 LOAD_ID,
  output logic                       INIT_PULSE,
  output logic                       TX_ACCEPT,
  output logic [3:0]                 RX_OVERFLOW
);
  import cehi_pkg::*;

  // Bus slave state
  logic        ack_ff, nxt_ack;
  logic [31:0] dat_ff, nxt_dat;
  logic        wr;
  logic [31:0] wd;

  // Initialisation state
  logic [6:0]  lid_ff, nxt_lid;
  logic [6:0]  lid_act_ff, nxt_lid_act;
  logic        init_en_ff, nxt_init_en;
  logic        ext_ff, nxt_ext;
  logic        ext_act_ff, nxt_ext_act;
  logic [15:0] rate_ff, nxt_rate;
  logic [15:0] rate_act_ff, nxt_rate_act;
  logic        init_ff, nxt_init;
  logic        soft_rst;
  logic        start_req;

  // Transmit state
  logic        tx_en_ff, nxt_tx_en;
  logic [28:0] tx_id_ff, nxt_tx_id;
  logic [3:0]  tx_dlc_ff, nxt_tx_dlc;
  logic [63:0] tx_data_ff, nxt_tx_data;
  logic        tx_done_ff, nxt_tx_done;
  logic        acc_ff, nxt_acc;
  logic        tx_go;
  logic        tx_id_ok;
  logic        tx_load;
  logic        tx_free;
  cehi_frame_t tx_req_frame;
  cehi_frame_t arb_frame;
  logic        arb_valid;

  // Receive state
  logic [1:0]  sel_ff, nxt_sel;
  logic        clr_ff, nxt_clr;
  logic [28:0] cfg_id_ff, nxt_cfg_id;
  logic [28:0] obj_id_ff [RX_OBJS], nxt_obj_id [RX_OBJS];
  logic [RX_OBJS-1:0] obj_cfg_ff, nxt_obj_cfg;
  cehi_frame_t rx_out_ff, nxt_rx_out;
  logic        rx_cfg_go;
  logic        rx_read_go;
  logic [RX_OBJS-1:0] q_push;
  logic [RX_OBJS-1:0] q_pop;
  logic [RX_OBJS-1:0] q_flush;
  cehi_frame_t q_head [RX_OBJS];
  logic [3:0]  q_count [RX_OBJS];
  logic [RX_OBJS-1:0] q_ovf;
  logic [28:0] rx_id_masked;

  // Wishbone classic slave: ack one cycle after the request, write applied on the ack edge
  always_comb
  begin
    nxt_ack = WB_CYC_I && WB_STB_I && !ack_ff;
    nxt_dat = 32'h0;
    unique case (WB_ADR_I)
      OFS_LOAD_ID:  nxt_dat = {25'h0, lid_ff};
      OFS_INIT:     nxt_dat = {27'h0, ext_act_ff, 1'b0, ext_ff, 1'b0, init_en_ff};
      OFS_BIT_RATE: nxt_dat = {rate_act_ff, rate_ff};
      OFS_TX_CTRL:  nxt_dat = {28'h0, !tx_free, tx_done_ff, 1'b0, tx_en_ff};
      OFS_TX_ID:    nxt_dat = {3'h0, tx_id_ff};
      OFS_TX_DLC:   nxt_dat = {28'h0, tx_dlc_ff};
      OFS_TX_DLO:   nxt_dat = tx_data_ff[31:0];
      OFS_TX_DHI:   nxt_dat = tx_data_ff[63:32];
      OFS_RX_CTRL:  nxt_dat = {28'h0, clr_ff, 1'b0, sel_ff};
      OFS_RX_CFGID: nxt_dat = {3'h0, cfg_id_ff};
      OFS_RX_STAT:  nxt_dat = {22'h0, obj_cfg_ff[sel_ff], q_ovf[sel_ff], 4'h0, q_count[sel_ff]};
      OFS_RX_ID:    nxt_dat = {3'h0, rx_out_ff.id};
      OFS_RX_DLC:   nxt_dat = {28'h0, rx_out_ff.dlc};
      OFS_RX_DLO:   nxt_dat = rx_out_ff.data[31:0];
      OFS_RX_DHI:   nxt_dat = rx_out_ff.data[63:32];
      default:      nxt_dat = 32'h0;
    endcase
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0;
    end
    else
    begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
    end
  end

  assign wr       = WB_CYC_I && WB_STB_I && WB_WE_I && ack_ff;
  assign wd       = wmask(WB_SEL_I, 32'h0, WB_DAT_I);
  assign WB_ACK_O = ack_ff;
  assign WB_DAT_O = dat_ff;

  // Initialisation, identifier mode and bit rate
  always_comb
  begin
    soft_rst     = wr && (WB_ADR_I == OFS_INIT) && wd[INIT_SOFT_RST];
    start_req    = wr && (WB_ADR_I == OFS_INIT) && wd[INIT_START] && wd[INIT_EN_BIT];
    nxt_lid      = lid_ff;
    nxt_lid_act  = lid_act_ff;
    nxt_init_en  = init_en_ff;
    nxt_ext      = ext_ff;
    nxt_ext_act  = ext_act_ff;
    nxt_rate     = rate_ff;
    nxt_rate_act = rate_act_ff;
    nxt_init     = start_req;
    if (wr && (WB_ADR_I == OFS_LOAD_ID) && wd[LID_EN_BIT] && (wd[6:0] != 7'h00))
      nxt_lid = wd[6:0];
    if (wr && (WB_ADR_I == OFS_INIT))
    begin
      nxt_init_en = wd[INIT_EN_BIT];
      nxt_ext     = wd[INIT_EXT_BIT];
    end
    if (start_req)
      nxt_ext_act = wd[INIT_EXT_BIT];
    if (wr && (WB_ADR_I == OFS_BIT_RATE) && rate_ok(wd[15:0]))
      nxt_rate = wd[15:0];
    if (soft_rst)
    begin
      nxt_rate_act = rate_ff;
      nxt_lid_act  = lid_ff;
    end
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      lid_ff      <= LOAD_ID_RST;
      lid_act_ff  <= LOAD_ID_RST;
      init_en_ff  <= 1'b0;
      ext_ff      <= 1'b0;
      ext_act_ff  <= 1'b0;
      rate_ff     <= BIT_RATE_RST;
      rate_act_ff <= BIT_RATE_RST;
      init_ff     <= 1'b0;
    end
    else
    begin
      lid_ff      <= nxt_lid;
      lid_act_ff  <= nxt_lid_act;
      init_en_ff  <= nxt_init_en;
      ext_ff      <= nxt_ext;
      ext_act_ff  <= nxt_ext_act;
      rate_ff     <= nxt_rate;
      rate_act_ff <= nxt_rate_act;
      init_ff     <= nxt_init;
    end
  end

  assign BIT_RATE   = rate_act_ff;
  assign EXT_MODE   = ext_act_ff;
  assign LOAD_ID    = lid_act_ff;
  assign INIT_PULSE = init_ff;

  // Transmit request intake
  always_comb
  begin
    tx_go        = wr && (WB_ADR_I == OFS_TX_CTRL) && wd[TXC_GO_BIT];
    tx_id_ok     = ext_act_ff || (tx_id_ff[28:11] == 18'h0);
    tx_load      = tx_go && tx_en_ff && tx_id_ok && tx_free && !init_ff;
    tx_req_frame.ext  = ext_act_ff;
    tx_req_frame.id   = tx_id_ff;
    tx_req_frame.dlc  = (tx_dlc_ff > DLC_MAX) ? DLC_MAX : tx_dlc_ff;
    tx_req_frame.data = tx_data_ff;
    nxt_tx_en   = tx_en_ff;
    nxt_tx_id   = tx_id_ff;
    nxt_tx_dlc  = tx_dlc_ff;
    nxt_tx_data = tx_data_ff;
    nxt_acc     = tx_load;
    nxt_tx_done = tx_done_ff;
    if (wr && (WB_ADR_I == OFS_TX_CTRL))
    begin
      nxt_tx_en = wd[TXC_EN_BIT];
      if (wd[TXC_DONE_BIT])
        nxt_tx_done = 1'b0;
    end
    if (tx_load)
      nxt_tx_done = 1'b1;
    if (wr && (WB_ADR_I == OFS_TX_ID))
      nxt_tx_id = 29'(wmask(WB_SEL_I, {3'h0, tx_id_ff}, WB_DAT_I));
    if (wr && (WB_ADR_I == OFS_TX_DLC))
      nxt_tx_dlc = wd[3:0];
    if (wr && (WB_ADR_I == OFS_TX_DLO))
      nxt_tx_data[31:0] = wmask(WB_SEL_I, tx_data_ff[31:0], WB_DAT_I);
    if (wr && (WB_ADR_I == OFS_TX_DHI))
      nxt_tx_data[63:32] = wmask(WB_SEL_I, tx_data_ff[63:32], WB_DAT_I);
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      tx_en_ff   <= 1'b0;
      tx_id_ff   <= 29'h0;
      tx_dlc_ff  <= 4'h0;
      tx_data_ff <= 64'h0;
      acc_ff     <= 1'b0;
      tx_done_ff <= 1'b0;
    end
    else
    begin
      tx_en_ff   <= nxt_tx_en;
      tx_id_ff   <= nxt_tx_id;
      tx_dlc_ff  <= nxt_tx_dlc;
      tx_data_ff <= nxt_tx_data;
      acc_ff     <= nxt_acc;
      tx_done_ff <= nxt_tx_done;
    end
  end

  assign TX_ACCEPT = acc_ff;

  // Pending transmit slots, lowest identifier offered first
  cehi_tx_arb u_tx_arb (
    .clk        (CLK),
    .reset      (RESET),
    .flush      (init_ff || soft_rst),
    .load       (tx_load),
    .load_frame (tx_req_frame),
    .has_free   (tx_free),
    .out_frame  (arb_frame),
    .out_valid  (arb_valid),
    .out_ready  (TX_READY)
  );

  assign TX_FRAME = arb_frame;
  assign TX_VALID = arb_valid;

  // Receive object configuration, read and clear
  always_comb
  begin
    rx_cfg_go    = wr && (WB_ADR_I == OFS_RX_CTRL) && wd[RXC_CFG_BIT];
    rx_read_go   = wr && (WB_ADR_I == OFS_RX_CTRL) && wd[RXC_READ_BIT];
    rx_id_masked = ext_act_ff ? RX_FRAME.id : {18'h0, RX_FRAME.id[10:0]};
    nxt_sel      = sel_ff;
    nxt_clr      = clr_ff;
    nxt_cfg_id   = cfg_id_ff;
    nxt_obj_id   = obj_id_ff;
    nxt_obj_cfg  = obj_cfg_ff;
    nxt_rx_out   = rx_out_ff;
    if (wr && (WB_ADR_I == OFS_RX_CTRL))
    begin
      nxt_sel = wd[RXC_SEL_LSB +: 2];
      nxt_clr = wd[RXC_CLR_BIT];
    end
    if (wr && (WB_ADR_I == OFS_RX_CFGID))
      nxt_cfg_id = 29'(wmask(WB_SEL_I, {3'h0, cfg_id_ff}, WB_DAT_I));
    if (rx_cfg_go)
    begin
      nxt_obj_id[wd[RXC_SEL_LSB +: 2]]  = ext_act_ff ? cfg_id_ff : {18'h0, cfg_id_ff[10:0]};
      nxt_obj_cfg[wd[RXC_SEL_LSB +: 2]] = 1'b1;
    end
    if (rx_read_go)
      nxt_rx_out = (q_count[wd[RXC_SEL_LSB +: 2]] != 4'h0) ? q_head[wd[RXC_SEL_LSB +: 2]] : '0;
    if (start_req || soft_rst)
      nxt_obj_cfg = '0;
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      sel_ff     <= 2'h0;
      clr_ff     <= 1'b0;
      cfg_id_ff  <= 29'h0;
      obj_cfg_ff <= '0;
      rx_out_ff  <= '0;
      for (int i = 0; i < RX_OBJS; i++)
        obj_id_ff[i] <= 29'h0;
    end
    else
    begin
      sel_ff     <= nxt_sel;
      clr_ff     <= nxt_clr;
      cfg_id_ff  <= nxt_cfg_id;
      obj_cfg_ff <= nxt_obj_cfg;
      rx_out_ff  <= nxt_rx_out;
      obj_id_ff  <= nxt_obj_id;
    end
  end

  // One FIFO per receive object, filled on identifier match
  generate
    for (genvar g = 0; g < RX_OBJS; g++)
    begin : g_rxq
      assign q_push[g]  = RX_VALID && obj_cfg_ff[g] && (RX_FRAME.ext == ext_act_ff) &&
                          (rx_id_masked == obj_id_ff[g]);
      assign q_pop[g]   = rx_read_go && (wd[RXC_SEL_LSB +: 2] == 2'(g));
      assign q_flush[g] = (clr_ff && (sel_ff == 2'(g))) || init_ff || soft_rst;
      cehi_rx_queue u_q (
        .clk        (CLK),
        .reset      (RESET),
        .flush      (q_flush[g]),
        .push       (q_push[g]),
        .push_frame (RX_FRAME),
        .pop        (q_pop[g]),
        .head       (q_head[g]),
        .count      (q_count[g]),
        .overflow   (q_ovf[g])
      );
    end
  endgenerate

  assign RX_OVERFLOW = q_ovf;
endmodule

/* File: rtl/cehi_tx_arb.sv */
module cehi_tx_arb (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 flush,
  input  wire logic                 load,
  input  wire cehi_pkg::cehi_frame_t load_frame,
  output logic                      has_free,
  output cehi_pkg::cehi_frame_t     out_frame,
  output logic                      out_valid,
  input  wire logic                 out_ready
);
  import cehi_pkg::*;

  cehi_frame_t            slot_ff [TX_SLOTS];
  cehi_frame_t            nxt_slot [TX_SLOTS];
  logic [TX_SLOTS-1:0]    vld_ff;
  logic [TX_SLOTS-1:0]    nxt_vld;
  cehi_frame_t            out_ff;
  cehi_frame_t            nxt_out;
  logic                   ov_ff;
  logic                   nxt_ov;
  logic [1:0]             free_idx;
  logic [1:0]             best_idx;
  logic                   any_vld;

  always_comb
  begin
    free_idx = 2'h0;
    best_idx = 2'h0;
    any_vld  = 1'b0;
    for (int i = TX_SLOTS - 1; i >= 0; i--)
    begin
      if (!vld_ff[i])
        free_idx = 2'(i);
    end
    for (int i = 0; i < TX_SLOTS; i++)
    begin
      if (vld_ff[i] && (!any_vld || slot_ff[i].id < slot_ff[best_idx].id))
      begin
        best_idx = 2'(i);
        any_vld  = 1'b1;
      end
    end
    nxt_slot = slot_ff;
    nxt_vld  = vld_ff;
    nxt_out  = out_ff;
    nxt_ov   = ov_ff && !out_ready;
    if ((!ov_ff || out_ready) && any_vld)
    begin
      nxt_out           = slot_ff[best_idx];
      nxt_ov            = 1'b1;
      nxt_vld[best_idx] = 1'b0;
    end
    if (load && !(&vld_ff))
    begin
      nxt_slot[free_idx] = load_frame;
      nxt_vld[free_idx]  = 1'b1;
    end
    if (flush)
    begin
      nxt_vld = '0;
      nxt_ov  = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      vld_ff <= '0;
      ov_ff  <= 1'b0;
      out_ff <= '0;
      for (int i = 0; i < TX_SLOTS; i++)
        slot_ff[i] <= '0;
    end
    else
    begin
      vld_ff  <= nxt_vld;
      ov_ff   <= nxt_ov;
      out_ff  <= nxt_out;
      slot_ff <= nxt_slot;
    end
  end

  assign has_free  = !(&vld_ff);
  assign out_frame = out_ff;
  assign out_valid = ov_ff;
endmodule
